// File: src/sebl_top.sv
// How it works
// - After reset, sample boot select; high starts reads from the serial memory.
// - Memory chip select is active low and asserted only during the read.
// - Serial clock is driven out at nominally 1.024 MHz from the master clock.
// - Serial output changes on falling clock edges, stable at the rising edge.
// - Memory changes input on falling edges; the loader samples on rising edges.
// - A read sends opcode 0x03 and a 16-bit address, then bytes stream back.
// - Serial port pins are released to high impedance whenever no read runs.
// - Configuration starts at address 0x10; locations 0x00 to 0x0F are skipped.
// - One command byte is read, then the words that command needs.
// - Commands run until filter start; after it no more memory reads happen.
// - Data words are three bytes, most significant byte first.
// - Command 0x01 takes register address and value and writes that register.
// - Command 0x02 takes two counts then first-stage then second-stage FIR words.
// - Each FIR stage count may be up to 255.
// - Command 0x03 takes exactly eight IIR words in fixed order.
// - Command 0x04 takes one word selecting built-in coefficient sets.
// - Command 0x05 takes a count and that many test pattern words.
// - Command 0x06 takes no words and selects the built-in test pattern.
// - Command 0x07 takes no words and initializes and starts the filter.
`timescale 1ns/1ps
`include "sebl_defines.svh"
module sebl_top #(
    parameter int FIFO_DEPTH = 4,
    parameter int HALF_CYC = `SEBL_HALF_CYC
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic BOOT_SEL,
    input wire logic MISO_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    output logic CFG_SERIAL_CLOCK_O,
    output logic CFG_SERIAL_CLOCK_OE,
    output logic ROM_SELECT_N_O,
    output logic ROM_SELECT_N_OE,
    output logic CFG_VALID,
    input wire logic CFG_READY,
    output logic [2:0] CFG_KIND,
    output logic [15:0] CFG_INDEX,
    output logic [23:0] CFG_DATA,
    output logic LOADER_DONE,
    output logic FILTER_START
);
    localparam int IW = $bits(sebl_pkg::sebl_item_t);

    sebl_byte_if bif ();

    sebl_pkg::sebl_state_t state_r;
    logic [2:0] boot_s_r;
    logic boot_f_r;
    logic [2:0] miso_s_r;
    logic miso_f_r;
    logic [3:0] settle_r;
    logic [1:0] hdr_r;
    logic [1:0] byte_r;
    logic [23:0] word_r;
    logic [23:0] word_nxt;
    logic [7:0] cmd_r;
    logic [15:0] stage_r;
    logic [15:0] addr_r;
    logic [7:0] n1_r;
    logic [7:0] n2_r;
    logic [15:0] ntbs_r;
    logic req_r;
    logic start_r;
    logic [7:0] tx_r;
    logic active_r;
    logic push_r;
    sebl_pkg::sebl_item_t push_item_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    sebl_pkg::sebl_item_t fifo_out;
    logic word_end;
    logic [15:0] fir_total;
    logic [15:0] fir_pos;
    logic pulls_bytes;

    assign bif.start = start_r;
    assign bif.tx = tx_r;
    assign word_nxt = {word_r[15:0], bif.rx};
    assign word_end = bif.done && (byte_r == `SEBL_LAST_BYTE);
    assign fir_total = 16'(n1_r) + 16'(n2_r);
    assign fir_pos = stage_r - 16'h0002;
    assign pulls_bytes = (state_r == sebl_pkg::ST_HDR) || (state_r == sebl_pkg::ST_CMD)
        || (state_r == sebl_pkg::ST_WORD);

    // Pins from outside pass three stages; a level is accepted only once
    // the last two stages agree, which rejects a single-cycle glitch.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            boot_s_r <= 3'h0;
            boot_f_r <= 1'b0;
            miso_s_r <= 3'h0;
            miso_f_r <= 1'b0;
        end else if (CE) begin
            boot_s_r <= {boot_s_r[1:0], BOOT_SEL};
            miso_s_r <= {miso_s_r[1:0], MISO_I};
            if (boot_s_r[1] == boot_s_r[2]) begin
                boot_f_r <= boot_s_r[2];
            end
            if (miso_s_r[1] == miso_s_r[2]) begin
                miso_f_r <= miso_s_r[2];
            end
        end
    end

    // Serial shift engine; the filtered input lags the pin by four cycles,
    // far less than the half period for which the memory holds its bit.
    sebl_spi_byte #(
        .HALF(HALF_CYC)
    ) u_eng (
        .clk(MCLK),
        .rst_n(ARST_N),
        .ce(CE),
        .miso(miso_f_r),
        .bif(bif),
        .sck(CFG_SERIAL_CLOCK_O),
        .mosi(MOSI_O)
    );

    // Main sequence: wait for the boot level to settle, then run one long
    // read that streams commands and data until the filter start command.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= sebl_pkg::ST_SETTLE;
            settle_r <= 4'h0;
        end else if (CE) begin
            case (state_r)
                sebl_pkg::ST_SETTLE: begin
                    if (settle_r == `SEBL_BOOT_SETTLE) begin
                        state_r <= boot_f_r ? sebl_pkg::ST_HDR : sebl_pkg::ST_IDLE;
                    end else begin
                        settle_r <= settle_r + 4'h1;
                    end
                end
                sebl_pkg::ST_HDR: begin
                    if (bif.done && (hdr_r == 2'h2)) begin
                        state_r <= sebl_pkg::ST_CMD;
                    end
                end
                sebl_pkg::ST_CMD: begin
                    if (bif.done) begin
                        case (bif.rx)
                            `SEBL_CMD_REG, `SEBL_CMD_FIR, `SEBL_CMD_IIR,
                            `SEBL_CMD_ROMSEL, `SEBL_CMD_TBS: begin
                                state_r <= sebl_pkg::ST_WORD;
                            end
                            `SEBL_CMD_START: begin
                                state_r <= sebl_pkg::ST_END;
                            end
                            default: begin
                                state_r <= sebl_pkg::ST_CMD;
                            end
                        endcase
                    end
                end
                sebl_pkg::ST_WORD: begin
                    if (word_end) begin
                        case (cmd_r)
                            `SEBL_CMD_REG: begin
                                if (stage_r == 16'h0001) begin
                                    state_r <= sebl_pkg::ST_CMD;
                                end
                            end
                            `SEBL_CMD_FIR: begin
                                if (stage_r == 16'h0001) begin
                                    if ((16'(n1_r) + 16'(word_nxt[7:0])) == 16'h0000) begin
                                        state_r <= sebl_pkg::ST_CMD;
                                    end
                                end else if (stage_r > 16'h0001) begin
                                    if (fir_pos == fir_total - 16'h0001) begin
                                        state_r <= sebl_pkg::ST_CMD;
                                    end
                                end
                            end
                            `SEBL_CMD_IIR: begin
                                if (stage_r == `SEBL_IIR_WORDS - 16'h0001) begin
                                    state_r <= sebl_pkg::ST_CMD;
                                end
                            end
                            `SEBL_CMD_TBS: begin
                                if (stage_r == 16'h0000) begin
                                    if (word_nxt[15:0] == 16'h0000) begin
                                        state_r <= sebl_pkg::ST_CMD;
                                    end
                                end else if (stage_r == ntbs_r) begin
                                    state_r <= sebl_pkg::ST_CMD;
                                end
                            end
                            default: begin
                                state_r <= sebl_pkg::ST_CMD;
                            end
                        endcase
                    end
                end
                sebl_pkg::ST_END: begin
                    state_r <= sebl_pkg::ST_DONE;
                end
                sebl_pkg::ST_IDLE, sebl_pkg::ST_DONE: begin
                    state_r <= state_r;
                end
                default: begin
                    state_r <= sebl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Byte and word counters, plus the counts that size each command.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hdr_r <= 2'h0;
            byte_r <= 2'h0;
            word_r <= 24'h00_0000;
            cmd_r <= 8'h00;
            stage_r <= 16'h0000;
            addr_r <= 16'h0000;
            n1_r <= 8'h00;
            n2_r <= 8'h00;
            ntbs_r <= 16'h0000;
        end else if (CE && bif.done) begin
            if (state_r == sebl_pkg::ST_HDR) begin
                hdr_r <= hdr_r + 2'h1;
            end else if (state_r == sebl_pkg::ST_CMD) begin
                cmd_r <= bif.rx;
                byte_r <= 2'h0;
                stage_r <= 16'h0000;
            end else if (state_r == sebl_pkg::ST_WORD) begin
                word_r <= word_nxt;
                byte_r <= word_end ? 2'h0 : byte_r + 2'h1;
                if (word_end) begin
                    stage_r <= stage_r + 16'h0001;
                    if ((cmd_r == `SEBL_CMD_REG) && (stage_r == 16'h0000)) begin
                        addr_r <= word_nxt[15:0];
                    end
                    if ((cmd_r == `SEBL_CMD_FIR) && (stage_r == 16'h0000)) begin
                        n1_r <= word_nxt[7:0];
                    end
                    if ((cmd_r == `SEBL_CMD_FIR) && (stage_r == 16'h0001)) begin
                        n2_r <= word_nxt[7:0];
                    end
                    if ((cmd_r == `SEBL_CMD_TBS) && (stage_r == 16'h0000)) begin
                        ntbs_r <= word_nxt[15:0];
                    end
                end
            end
        end
    end

    // Decoded writes are queued as one item per cycle; nothing is queued
    // for counts, the register address word, or skipped codes.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            push_r <= 1'b0;
            push_item_r <= '0;
        end else if (CE) begin
            push_r <= 1'b0;
            push_item_r.data <= word_nxt;
            push_item_r.index <= stage_r;
            if (bif.done && (state_r == sebl_pkg::ST_CMD)) begin
                push_item_r.index <= 16'h0000;
                push_item_r.data <= 24'h00_0000;
                if (bif.rx == `SEBL_CMD_TBSROM) begin
                    push_r <= 1'b1;
                    push_item_r.kind <= sebl_pkg::K_TBSROM;
                end
                if (bif.rx == `SEBL_CMD_START) begin
                    push_r <= 1'b1;
                    push_item_r.kind <= sebl_pkg::K_START;
                end
            end else if (word_end && (state_r == sebl_pkg::ST_WORD)) begin
                case (cmd_r)
                    `SEBL_CMD_REG: begin
                        push_r <= (stage_r == 16'h0001);
                        push_item_r.kind <= sebl_pkg::K_REG;
                        push_item_r.index <= addr_r;
                    end
                    `SEBL_CMD_FIR: begin
                        push_r <= (stage_r > 16'h0001);
                        if (fir_pos < 16'(n1_r)) begin
                            push_item_r.kind <= sebl_pkg::K_FIRST_FIR_STAGE;
                            push_item_r.index <= fir_pos;
                        end else begin
                            push_item_r.kind <= sebl_pkg::K_SECOND_FIR_STAGE;
                            push_item_r.index <= fir_pos - 16'(n1_r);
                        end
                    end
                    `SEBL_CMD_IIR: begin
                        push_r <= 1'b1;
                        push_item_r.kind <= sebl_pkg::K_IIR;
                    end
                    `SEBL_CMD_ROMSEL: begin
                        push_r <= 1'b1;
                        push_item_r.kind <= sebl_pkg::K_ROMSEL;
                    end
                    `SEBL_CMD_TBS: begin
                        push_r <= (stage_r != 16'h0000);
                        push_item_r.kind <= sebl_pkg::K_TBS;
                        push_item_r.index <= stage_r - 16'h0001;
                    end
                    default: begin
                        push_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // A byte is started only when the queue can take whatever it yields,
    // so back-pressure stalls the serial clock instead of losing data.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_r <= 1'b0;
            start_r <= 1'b0;
            tx_r <= 8'h00;
        end else if (CE) begin
            start_r <= 1'b0;
            if (bif.done) begin
                req_r <= 1'b0;
            end else if (pulls_bytes && active_r && !req_r && !push_r && fifo_in_ready) begin
                req_r <= 1'b1;
                start_r <= 1'b1;
                case (hdr_r)
                    2'h0: tx_r <= `SEBL_OP_READ;
                    2'h1: tx_r <= 8'(`SEBL_CFG_BASE >> 8);
                    2'h2: tx_r <= 8'(`SEBL_CFG_BASE & 16'h00ff);
                    default: tx_r <= 8'h00;
                endcase
                if (state_r != sebl_pkg::ST_HDR) begin
                    tx_r <= 8'h00;
                end
            end
        end
    end

    // Chip select and the drivers are on only for the one read; the port
    // floats otherwise so a programmer can reach the memory in circuit.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            active_r <= 1'b0;
            ROM_SELECT_N_O <= 1'b1;
        end else if (CE) begin
            active_r <= pulls_bytes;
            ROM_SELECT_N_O <= !pulls_bytes;
        end
    end

    assign ROM_SELECT_N_OE = active_r;
    assign MOSI_OE = active_r;
    assign CFG_SERIAL_CLOCK_OE = active_r;

    sebl_fifo #(
        .WIDTH(IW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(ARST_N),
        .ce(CE),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(push_item_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    assign fifo_out_ready = !CFG_VALID || CFG_READY;

    // Output stage keeps every item port on a flop; it reloads in the cycle
    // the consumer takes the current item, so full rate is kept.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CFG_VALID <= 1'b0;
            CFG_KIND <= 3'h0;
            CFG_INDEX <= 16'h0000;
            CFG_DATA <= 24'h00_0000;
            FILTER_START <= 1'b0;
        end else if (CE) begin
            FILTER_START <= CFG_VALID && CFG_READY && (CFG_KIND == 3'(sebl_pkg::K_START));
            if (fifo_out_ready) begin
                CFG_VALID <= fifo_out_valid;
                CFG_KIND <= fifo_out.kind;
                CFG_INDEX <= fifo_out.index;
                CFG_DATA <= fifo_out.data;
            end
        end
    end

    // Done once the start item has been handed over.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LOADER_DONE <= 1'b0;
        end else if (CE && FILTER_START) begin
            LOADER_DONE <= 1'b1;
        end
    end
endmodule

// File: src/sebl_defines.svh
`ifndef SEBL_DEFINES_SVH
`define SEBL_DEFINES_SVH
// Master clock rate and nominal serial clock rate, in hertz.
`define SEBL_MCLK_HZ 40000000
`define SEBL_SCK_HZ 1024000
// Master clock cycles per serial clock half period, rounded down.
`define SEBL_HALF_CYC (`SEBL_MCLK_HZ / (2 * `SEBL_SCK_HZ))
// Cycles waited after reset release before the boot select is taken.
`define SEBL_BOOT_SETTLE 4'h4
// Serial memory read opcode and first configuration address.
`define SEBL_OP_READ 8'h03
`define SEBL_CFG_BASE 16'h0010
// Configuration command codes.
`define SEBL_CMD_NOP 8'h00
`define SEBL_CMD_REG 8'h01
`define SEBL_CMD_FIR 8'h02
`define SEBL_CMD_IIR 8'h03
`define SEBL_CMD_ROMSEL 8'h04
`define SEBL_CMD_TBS 8'h05
`define SEBL_CMD_TBSROM 8'h06
`define SEBL_CMD_START 8'h07
// Fixed number of IIR coefficient words.
`define SEBL_IIR_WORDS 16'h0008
// Last byte index of a 24-bit data word.
`define SEBL_LAST_BYTE 2'h2
`endif

// File: src/sebl_pkg.sv
package sebl_pkg;
    typedef enum logic [2:0] {
        ST_SETTLE, ST_IDLE, ST_HDR, ST_CMD, ST_WORD, ST_END, ST_DONE
    } sebl_state_t;
    typedef enum logic [2:0] {
        K_REG, K_FIRST_FIR_STAGE, K_SECOND_FIR_STAGE, K_IIR, K_ROMSEL, K_TBS, K_TBSROM, K_START
    } sebl_kind_t;
    typedef struct packed {
        sebl_kind_t kind;
        logic [15:0] index;
        logic [23:0] data;
    } sebl_item_t;
endpackage

// File: src/sebl_byte_if.sv
`timescale 1ns/1ps
// One serial byte exchange between the loader and the shift engine.
interface sebl_byte_if;
    logic start;
    logic [7:0] tx;
    logic busy;
    logic done;
    logic [7:0] rx;
    modport ctl (output start, output tx, input busy, input done, input rx);
    modport eng (input start, input tx, output busy, output done, output rx);
endinterface

// File: src/sebl_fifo.sv
`timescale 1ns/1ps
module sebl_fifo #(
    parameter int WIDTH = 43,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage has no reset; only the pointers and the count need a defined value.
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_r] <= in_data;
        end
    end

    // Pointers wrap explicitly so a depth that is not a power of two works.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: src/sebl_spi_byte.sv
`timescale 1ns/1ps
`include "sebl_defines.svh"
module sebl_spi_byte #(
    parameter int HALF = `SEBL_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic miso,
    sebl_byte_if.eng bif,
    output logic sck,
    output logic mosi
);
    localparam int DW = $clog2(HALF + 1);
    logic [DW-1:0] div_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] rx_r;

    assign bif.rx = rx_r;

    // Mode 0 byte engine: data out is set up before the first rising edge,
    // input is taken on each rising edge, output moves on each falling edge but the last.
    // The clock rests low between bytes, so a stall simply stretches it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            rx_r <= 8'h00;
            sck <= 1'b0;
            mosi <= 1'b0;
            bif.busy <= 1'b0;
            bif.done <= 1'b0;
        end else if (ce) begin
            bif.done <= 1'b0;
            if (!bif.busy) begin
                if (bif.start) begin
                    bif.busy <= 1'b1;
                    sh_r <= bif.tx;
                    mosi <= bif.tx[7];
                    div_r <= '0;
                    bit_r <= 3'h0;
                    sck <= 1'b0;
                end
            end else if (div_r == DW'(HALF - 1)) begin
                div_r <= '0;
                if (!sck) begin
                    sck <= 1'b1;
                    rx_r <= {rx_r[6:0], miso};
                end else begin
                    sck <= 1'b0;
                    if (bit_r == 3'h7) begin
                        bif.busy <= 1'b0;
                        bif.done <= 1'b1;
                    end else begin
                        bit_r <= bit_r + 3'h1;
                        sh_r <= {sh_r[6:0], 1'b0};
                        mosi <= sh_r[6];
                    end
                end
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end
endmodule

// File: sim/sebl_properties.sv
`timescale 1ns/1ps
module sebl_checker (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic MOSI_O,
    input wire logic MOSI_OE,
    input wire logic CFG_SERIAL_CLOCK_O,
    input wire logic CFG_SERIAL_CLOCK_OE,
    input wire logic ROM_SELECT_N_O,
    input wire logic ROM_SELECT_N_OE,
    input wire logic CFG_VALID,
    input wire logic CFG_READY,
    input wire logic [2:0] CFG_KIND,
    input wire logic [23:0] CFG_DATA,
    input wire logic LOADER_DONE,
    input wire logic FILTER_START
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // The start item is handed over, then a single pulse and the done level follow.
    sequence s_take_start;
        CE && CFG_VALID && CFG_READY && CFG_KIND == 3'h7;
    endsequence
    sequence s_pulse;
        FILTER_START ##1 (!FILTER_START && LOADER_DONE);
    endsequence
    a_start_pulse: assert property (s_take_start |=> s_pulse) else $error("bad start");
    a_sel_drives: assert property (!ROM_SELECT_N_O |->
        ROM_SELECT_N_OE && MOSI_OE && CFG_SERIAL_CLOCK_OE) else $error("select undriven");
    a_idle_released: assert property (!ROM_SELECT_N_OE |->
        !MOSI_OE && !CFG_SERIAL_CLOCK_OE) else $error("port not released");
    a_mosi_on_low: assert property ($changed(MOSI_O) && MOSI_OE |->
        !CFG_SERIAL_CLOCK_O) else $error("data moved on high clock");
    a_sck_framed: assert property (ROM_SELECT_N_O |-> !CFG_SERIAL_CLOCK_O) else $error("clk");
    a_hold_item: assert property (CFG_VALID && !CFG_READY |=>
        CFG_VALID && $stable({CFG_KIND, CFG_DATA})) else $error("item dropped");
    a_done_quiet: assert property (LOADER_DONE |->
        ROM_SELECT_N_O && !ROM_SELECT_N_OE && !CFG_VALID) else $error("activity after done");
    a_done_sticky: assert property (LOADER_DONE |=> LOADER_DONE) else $error("done fell");
endmodule
bind sebl_top sebl_checker sebl_checker_inst (.*);

// File: sim/sebl_eeprom_model.sv
`timescale 1ns/1ps
module sebl_eeprom_model (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso
);
    logic [7:0] mem [0:255];
    logic [22:0] sh;
    logic [7:0] op;
    logic [15:0] adr;
    int cnt = 0;
    int reads = 0;
    initial miso = 1'b0;
    // Opcode and address are taken on rising edges, most significant bit first.
    always @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt <= 0;
        end else begin
            sh <= {sh[21:0], mosi};
            cnt <= cnt + 1;
            if (cnt == 23) begin
                op <= sh[22:15];
                adr <= {sh[14:0], mosi};
            end
        end
    end
    // Bytes stream from the address on falling edges; an idle line toggles, never holds.
    always @(negedge sck or posedge cs_n) begin
        if (cs_n || cnt < 24) miso <= ~miso;
        else miso <= mem[8'(adr + 16'((cnt - 24) / 8))][3'(7 - (cnt - 24) % 8)];
    end
    always @(negedge cs_n) reads++;
endmodule

// File: sim/test_spi_eeprom_boot_loader.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module test_spi_eeprom_boot_loader;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic boot = 1'b0;
    logic rdy = 1'b0;
    logic mosi, mosi_oe, sck, sck_oe, sel_n, sel_oe, vld, done, start, miso;
    logic [2:0] kind;
    logic [15:0] idx;
    logic [23:0] dat;
    logic [42:0] exp_q[$];
    int err_total = 0;
    int comparisons = 0;
    int wp = 16, starts = 0;
    // Select has a pull-up; the released clock reads low and released data reads inverted.
    wire sck_w = sck_oe ? sck : 1'b0;
    wire sel_w = sel_oe ? sel_n : 1'b1;
    wire mosi_w = mosi_oe ? mosi : ~mosi;
    sebl_top sebl_top_inst (.MCLK(mclk), .ARST_N(arst_n), .CE(1'b1), .BOOT_SEL(boot),
        .MISO_I(miso), .MOSI_O(mosi), .MOSI_OE(mosi_oe), .CFG_SERIAL_CLOCK_O(sck),
        .CFG_SERIAL_CLOCK_OE(sck_oe), .ROM_SELECT_N_O(sel_n), .ROM_SELECT_N_OE(sel_oe),
        .CFG_VALID(vld), .CFG_READY(rdy), .CFG_KIND(kind), .CFG_INDEX(idx),
        .CFG_DATA(dat), .LOADER_DONE(done), .FILTER_START(start));
    sebl_eeprom_model sebl_eeprom_model_inst (.sck(sck_w), .cs_n(sel_w), .mosi(mosi_w),
        .miso(miso));
    // Master clock of 25 ns.
    initial forever #12.5 mclk = ~mclk;
    task automatic put(input logic [7:0] b);
        sebl_eeprom_model_inst.mem[wp] = b;
        wp++;
    endtask
    // A command byte; codes without data words may yield an item at once.
    task automatic cmd(input logic [7:0] b, input logic [3:0] k);
        put(b);
        if (!k[3]) exp_q.push_back({k[2:0], 16'h0000, 24'h00_0000});
    endtask
    // A data word goes high byte first; counts and addresses yield no item.
    task automatic wd(input logic [23:0] w, input logic [3:0] k, input logic [15:0] i);
        put(w[23:16]);
        put(w[15:8]);
        put(w[7:0]);
        if (!k[3]) exp_q.push_back({k[2:0], i, w});
    endtask
    task automatic do_reset(input logic b);
        arst_n <= 1'b0;
        boot <= b;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
    endtask
    // Junk everywhere, so a read of the header or past the end shows up as items.
    task automatic fill_rom;
        for (int a = 0; a < 256; a++) sebl_eeprom_model_inst.mem[a] = 8'h01;
        cmd(8'h00, 4'h8);
        cmd(8'h09, 4'h8);
        cmd(8'h01, 4'h8);
        wd(24'h00_0020, 4'h8, 16'h0000);
        wd(24'h00_0240, 4'h0, 16'h0020);
        cmd(8'h02, 4'h8);
        wd(24'h00_0001, 4'h8, 16'h0000);
        wd(24'h00_0002, 4'h8, 16'h0000);
        wd(24'hAA_BBCC, 4'h1, 16'h0000);
        wd(24'h11_2233, 4'h2, 16'h0000);
        wd(24'h44_5566, 4'h2, 16'h0001);
        cmd(8'h03, 4'h8);
        for (int i = 0; i < 8; i++) wd({8'(i), 16'hA5C3}, 4'h3, 16'(i));
        cmd(8'h04, 4'h8);
        wd(24'h00_2200, 4'h4, 16'h0000);
        cmd(8'h05, 4'h8);
        wd(24'h00_0002, 4'h8, 16'h0000);
        wd(24'h00_07DA, 4'h5, 16'h0000);
        wd(24'h00_0FB5, 4'h5, 16'h0001);
        cmd(8'h06, 4'h6);
        cmd(8'h07, 4'h7);
    endtask
    task automatic boot_low;
        do_reset(1'b0);
        repeat (400) @(posedge mclk);
        `CHK("oe", 3'b000, {mosi_oe, sck_oe, sel_oe})
        `CHK("valid", 1'b0, vld)
    endtask
    // Consumer stalls first, so the queue fills and the serial clock must stop.
    task automatic boot_high;
        int mc;
        logic [42:0] e;
        do_reset(1'b1);
        for (int n = 0; n < 60000 && done !== 1'b1; n++) begin
            @(posedge mclk);
            if (n == 11000) mc = sebl_eeprom_model_inst.cnt;
            if (n == 11999) `CHK("stall", mc, sebl_eeprom_model_inst.cnt)
            if (vld === 1'b1 && rdy === 1'b1) begin
                e = exp_q.pop_front();
                `CHK("item", e, {kind, idx, dat})
            end
            if (start === 1'b1) starts++;
            rdy <= n > 12000;
        end
        repeat (40) @(posedge mclk);
        `CHK("left", 0, exp_q.size())
        `CHK("starts", 1, starts)
        `CHK("reads", 1, sebl_eeprom_model_inst.reads)
        `CHK("opcode", 8'h03, sebl_eeprom_model_inst.op)
        `CHK("addr", 16'h0010, sebl_eeprom_model_inst.adr)
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        fill_rom;
        boot_low;
        boot_high;
        tally_and_finish;
    end
    // The load takes some 24k cycles, so 80k cycles means a hang.
    initial begin
        #2_000_000;
        err_total++;
        tally_and_finish;
    end
endmodule
